// ### adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_POWER    = 8'h08;
  localparam logic [7:0] ADDR_CLK_STAB = 8'h09;
  localparam logic [7:0] ADDR_CLK_DIV  = 8'h0B;
  localparam logic [7:0] ADDR_TEST     = 8'h0D;
  localparam logic [7:0] ADDR_OFFSET   = 8'h10;
  localparam logic [7:0] ADDR_USER1_LO = 8'h19;
  localparam logic [7:0] ADDR_USER1_HI = 8'h1A;
  localparam logic [7:0] ADDR_COMMIT   = 8'hFF;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] POWER_RST    = 8'h00;
  localparam logic [7:0] CLK_STAB_RST = 8'h01;
  localparam logic [7:0] CLK_DIV_RST  = 8'h00;
  localparam logic [7:0] TEST_RST     = 8'h00;
  localparam logic [7:0] OFFSET_RST   = 8'h00;
  localparam logic [7:0] USER_LO_RST  = 8'h00;
  localparam logic [7:0] USER_HI_RST  = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int PWR_LSB       = 0;
  localparam int DCS_BIT       = 0;
  localparam int DIV_RATIO_LSB = 0;
  localparam int DIV_PHASE_LSB = 3;
  localparam int TEST_SEL_LSB  = 0;
  localparam int SHORT_RST_BIT = 4;
  localparam int LONG_RST_BIT  = 5;
  localparam int TEST_ONCE_BIT = 7;
  localparam int OFFSET_LSB    = 0;
  localparam int COMMIT_BIT    = 0;

  // ==========================================================================
  // Encodings and data path
  localparam logic [1:0] PWR_NORMAL  = 2'h0;
  localparam logic [1:0] PWR_OFF     = 2'h1;
  localparam logic [1:0] PWR_STANDBY = 2'h2;

  localparam logic [3:0] SEL_OFF     = 4'h0;
  localparam logic [3:0] SEL_MID     = 4'h1;
  localparam logic [3:0] SEL_POS_FS  = 4'h2;
  localparam logic [3:0] SEL_NEG_FS  = 4'h3;
  localparam logic [3:0] SEL_CHECKER = 4'h4;
  localparam logic [3:0] SEL_PN_LONG = 4'h5;
  localparam logic [3:0] SEL_PN_SHRT = 4'h6;
  localparam logic [3:0] SEL_TOGGLE  = 4'h7;
  localparam logic [3:0] SEL_USER    = 4'h8;
  localparam logic [3:0] SEL_RAMP    = 4'hF;

  localparam int DATA_W     = 12;
  localparam int FIFO_DEPTH = 8;

  localparam logic [11:0] WORD_MID    = 12'h000;
  localparam logic [11:0] WORD_POS_FS = 12'h7FF;
  localparam logic [11:0] WORD_NEG_FS = 12'h800;
  localparam logic [11:0] WORD_CHK_A  = 12'hAAA;
  localparam logic [11:0] WORD_CHK_B  = 12'h555;
  localparam logic [11:0] WORD_ONES   = 12'hFFF;
  localparam logic [11:0] WORD_ZERO   = 12'h000;

  localparam int          PN_LONG_W    = 23;
  localparam int          PN_LONG_TAP  = 18;
  localparam logic [22:0] PN_LONG_SEED = 23'h7FFFFF;
  localparam int          PN_SHRT_W    = 9;
  localparam int          PN_SHRT_TAP  = 5;
  localparam logic [8:0]  PN_SHRT_SEED = 9'h1FF;

  // ==========================================================================
  // Types
  typedef enum logic {PAT_RUN, PAT_DONE} pat_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [1:0]  pwr;
    logic        dcs_en;
    logic [2:0]  div_phase;
    logic [2:0]  div_ratio;
    logic        test_once;
    logic        long_rst;
    logic        short_rst;
    logic [3:0]  test_sel;
    logic [5:0]  offset;
    logic [15:0] user1;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    pwr:       POWER_RST[PWR_LSB +: 2],
    dcs_en:    CLK_STAB_RST[DCS_BIT],
    div_phase: CLK_DIV_RST[DIV_PHASE_LSB +: 3],
    div_ratio: CLK_DIV_RST[DIV_RATIO_LSB +: 3],
    test_once: TEST_RST[TEST_ONCE_BIT],
    long_rst:  TEST_RST[LONG_RST_BIT],
    short_rst: TEST_RST[SHORT_RST_BIT],
    test_sel:  TEST_RST[TEST_SEL_LSB +: 4],
    offset:    OFFSET_RST[OFFSET_LSB +: 6],
    user1:     {USER_HI_RST, USER_LO_RST}
  };

endpackage

// ### sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ### pn_sequence.sv
`timescale 1ns/1ps
module pn_sequence
  import adc_ctrl_pkg::*;
#(
  parameter int           WIDTH = 9,
  parameter int           TAP   = 5,
  parameter logic [WIDTH-1:0] SEED = '1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             restart,
  input  wire logic             step,
  output logic      [WIDTH-1:0] state
);
  // Fibonacci shift register, seed held while restart is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SEED;
    end else if (ce) begin
      if (restart) begin
        state <= SEED;
      end else if (step) begin
        state <= {state[WIDTH-2:0], state[WIDTH-1] ^ state[TAP-1]};
      end
    end
  end
endmodule

// ### adc_control_register_bank.sv
`timescale 1ns/1ps
module adc_control_register_bank
  import adc_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire reg_req_t          reg_req,
  output logic      [7:0]        reg_rdata,
  input  wire logic [DATA_W-1:0] sample_data,
  input  wire logic              sample_valid,
  output logic                   sample_ready,
  output logic      [DATA_W-1:0] out_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic                   div_clk_tick,
  output logic                   dcs_active,
  output logic                   power_down,
  output logic                   standby
);

  // ==========================================================================
  // Shadow and active settings
  cfg_t       shadow_reg;
  cfg_t       active_reg;
  logic       commit_reg;
  logic       commit_wr;
  logic [7:0] rd_next;

  assign commit_wr = reg_req.wr && (reg_req.addr == ADDR_COMMIT) &&
                     reg_req.wdata[COMMIT_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow_reg <= CFG_RESET;
    end else if (ce && reg_req.wr) begin
      case (reg_req.addr)
        ADDR_POWER:    shadow_reg.pwr    <= reg_req.wdata[PWR_LSB +: 2];
        ADDR_CLK_STAB: shadow_reg.dcs_en <= reg_req.wdata[DCS_BIT];
        ADDR_CLK_DIV: begin
          shadow_reg.div_ratio <= reg_req.wdata[DIV_RATIO_LSB +: 3];
          shadow_reg.div_phase <= reg_req.wdata[DIV_PHASE_LSB +: 3];
        end
        ADDR_TEST: begin
          shadow_reg.test_sel  <= reg_req.wdata[TEST_SEL_LSB +: 4];
          shadow_reg.short_rst <= reg_req.wdata[SHORT_RST_BIT];
          shadow_reg.long_rst  <= reg_req.wdata[LONG_RST_BIT];
          shadow_reg.test_once <= reg_req.wdata[TEST_ONCE_BIT];
        end
        ADDR_OFFSET:   shadow_reg.offset <= reg_req.wdata[OFFSET_LSB +: 6];
        ADDR_USER1_LO: shadow_reg.user1[7:0] <= reg_req.wdata;
        ADDR_USER1_HI: shadow_reg.user1[15:8] <= reg_req.wdata;
        default:       ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      commit_reg <= 1'b0;
    end else if (ce) begin
      commit_reg <= commit_wr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_reg <= CFG_RESET;
    end else if (ce && commit_reg) begin
      active_reg <= shadow_reg;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    case (reg_req.addr)
      ADDR_POWER:    rd_next[PWR_LSB +: 2] = shadow_reg.pwr;
      ADDR_CLK_STAB: rd_next[DCS_BIT] = shadow_reg.dcs_en;
      ADDR_CLK_DIV: begin
        rd_next[DIV_RATIO_LSB +: 3] = shadow_reg.div_ratio;
        rd_next[DIV_PHASE_LSB +: 3] = shadow_reg.div_phase;
      end
      ADDR_TEST: begin
        rd_next[TEST_SEL_LSB +: 4] = shadow_reg.test_sel;
        rd_next[SHORT_RST_BIT]     = shadow_reg.short_rst;
        rd_next[LONG_RST_BIT]      = shadow_reg.long_rst;
        rd_next[TEST_ONCE_BIT]     = shadow_reg.test_once;
      end
      ADDR_OFFSET:   rd_next[OFFSET_LSB +: 6] = shadow_reg.offset;
      ADDR_USER1_LO: rd_next = shadow_reg.user1[7:0];
      ADDR_USER1_HI: rd_next = shadow_reg.user1[15:8];
      ADDR_COMMIT:   rd_next[COMMIT_BIT] = commit_reg;
      default:       rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_req.rd) begin
      reg_rdata <= rd_next;
    end
  end

  // ==========================================================================
  // Power state and clock divider
  logic [2:0] div_cnt_reg;
  logic [7:0] div_dly_reg;

  // power field decode, reserved code treated as normal
  assign power_down = (active_reg.pwr == PWR_OFF);
  assign standby    = (active_reg.pwr == PWR_STANDBY);

  // stabilizer on by default or with any divide
  assign dcs_active = active_reg.dcs_en || (active_reg.div_ratio != 3'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 3'h0;
    end else if (ce) begin
      if (commit_reg || div_cnt_reg >= active_reg.div_ratio) begin
        div_cnt_reg <= 3'h0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 3'h1;
      end
    end
  end

  // delay line tap, stale pulses flushed on commit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_dly_reg <= 8'h00;
    end else if (ce) begin
      div_dly_reg <= commit_reg ? 8'h00 : {div_dly_reg[6:0], div_cnt_reg == 3'h0};
    end
  end

  assign div_clk_tick = div_dly_reg[active_reg.div_phase];

  // ==========================================================================
  // Sample buffer and pattern generators
  logic [DATA_W-1:0]    fifo_data;
  logic                 fifo_valid;
  logic                 advance;
  logic                 in_test;
  logic                 toggle_reg;
  logic [DATA_W-1:0]    ramp_reg;
  logic [PN_LONG_W-1:0] pn_long;
  logic [PN_SHRT_W-1:0] pn_short;
  pat_state_t           pat_state;
  logic [DATA_W-1:0]    test_word;
  logic [DATA_W-1:0]    norm_word;
  logic signed [DATA_W+1:0] sum;

  assign in_test = (active_reg.test_sel != SEL_OFF);
  assign advance = ce && fifo_valid && (!out_valid || out_ready) &&
                   !power_down && !standby;

  sample_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (advance)
  );

  // seed held while restart bit set
  pn_sequence #(
    .WIDTH (PN_LONG_W),
    .TAP   (PN_LONG_TAP),
    .SEED  (PN_LONG_SEED)
  ) u_pn_long (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .restart (active_reg.long_rst),
    .step    (advance && active_reg.test_sel == SEL_PN_LONG),
    .state   (pn_long)
  );

  pn_sequence #(
    .WIDTH (PN_SHRT_W),
    .TAP   (PN_SHRT_TAP),
    .SEED  (PN_SHRT_SEED)
  ) u_pn_short (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .restart (active_reg.short_rst),
    .step    (advance && active_reg.test_sel == SEL_PN_SHRT),
    .state   (pn_short)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toggle_reg <= 1'b0;
      ramp_reg   <= '0;
    end else if (ce && commit_reg) begin
      toggle_reg <= 1'b0;
      ramp_reg   <= '0;
    end else if (advance) begin
      toggle_reg <= !toggle_reg;
      ramp_reg   <= ramp_reg + 1'b1;
    end
  end

  // one word in single mode, then zeros until next commit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pat_state <= PAT_RUN;
    end else if (ce) begin
      case (pat_state)
        PAT_RUN: begin
          if (!commit_reg && advance && in_test && active_reg.test_once) begin
            pat_state <= PAT_DONE;
          end
        end
        PAT_DONE: begin
          if (commit_reg) begin
            pat_state <= PAT_RUN;
          end
        end
        default: pat_state <= PAT_RUN;
      endcase
    end
  end

  always_comb begin
    case (active_reg.test_sel)
      SEL_MID:     test_word = WORD_MID;
      SEL_POS_FS:  test_word = WORD_POS_FS;
      SEL_NEG_FS:  test_word = WORD_NEG_FS;
      SEL_CHECKER: test_word = toggle_reg ? WORD_CHK_B : WORD_CHK_A;
      SEL_PN_LONG: test_word = pn_long[DATA_W-1:0];
      SEL_PN_SHRT: test_word = {3'h0, pn_short};
      SEL_TOGGLE:  test_word = toggle_reg ? WORD_ZERO : WORD_ONES;
      SEL_USER:    test_word = active_reg.user1[15 -: DATA_W];
      SEL_RAMP:    test_word = ramp_reg;
      default:     test_word = WORD_ZERO;
    endcase
  end

  always_comb begin
    sum = $signed({{2{fifo_data[DATA_W-1]}}, fifo_data}) +
          $signed({{(DATA_W-4){active_reg.offset[5]}}, active_reg.offset});
    if (sum > $signed({2'b00, WORD_POS_FS})) begin
      norm_word = WORD_POS_FS;
    end else if (sum < $signed({2'b11, WORD_NEG_FS})) begin
      norm_word = WORD_NEG_FS;
    end else begin
      norm_word = sum[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (advance) begin
        out_valid <= 1'b1;
        if (!in_test) begin
          out_data <= norm_word;
        end else if (pat_state == PAT_DONE) begin
          out_data <= WORD_ZERO;
        end else begin
          out_data <= test_word;
        end
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_commit_copies;
    ce && commit_reg |=> active_reg == $past(shadow_reg);
  endproperty
  a_commit_copies: assert property (p_commit_copies)
    else $error("active settings differ from shadow after commit");
  property p_no_early_effect;
    !commit_reg |=> $stable(active_reg);
  endproperty
  a_no_early_effect: assert property (p_no_early_effect)
    else $error("active settings changed without commit");
  property p_commit_clears;
    ce && commit_reg && !commit_wr |=> !commit_reg;
  endproperty
  a_commit_clears: assert property (p_commit_clears)
    else $error("commit bit did not clear");
  property p_power_stall;
    power_down || standby |-> !advance;
  endproperty
  a_power_stall: assert property (p_power_stall)
    else $error("data moved while powered down");
  property p_divide_forces_dcs;
    active_reg.div_ratio != 3'h0 |-> dcs_active;
  endproperty
  a_divide_forces_dcs: assert property (p_divide_forces_dcs)
    else $error("stabilizer off with divider active");

  property p_long_seed;
    ce && active_reg.long_rst ##1 active_reg.long_rst |-> pn_long == PN_LONG_SEED;
  endproperty
  a_long_seed: assert property (p_long_seed)
    else $error("long sequence not at seed during restart");

  property p_pos_fs;
    advance && active_reg.test_sel == SEL_POS_FS && pat_state == PAT_RUN
      |=> out_valid && out_data == WORD_POS_FS;
  endproperty
  a_pos_fs: assert property (p_pos_fs)
    else $error("positive full-scale word wrong");

  property p_once_zeros;
    advance && in_test && pat_state == PAT_DONE |=> out_data == WORD_ZERO;
  endproperty
  a_once_zeros: assert property (p_once_zeros)
    else $error("single pattern mode not emitting zeros");

  property p_tick_phase;
    ce && !commit_reg && div_cnt_reg == 3'h0 && active_reg.div_phase == 3'h0
      |-> ##1 (div_dly_reg[0]);
  endproperty
  a_tick_phase: assert property (p_tick_phase)
    else $error("divided clock tick missing at zero phase");

endmodule

// ### reg_host.sv
`timescale 1ns/1ps
module reg_host
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output reg_req_t        req
);
  initial req = '0;

  // ==========================================================================
  // Register cycles, released fields show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    d = rdata;
  endtask

  task automatic commit();
    wr(ADDR_COMMIT, 8'h01);
  endtask
endmodule

// ### adc_control_register_bank_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module adc_control_register_bank_tb_top
  import adc_ctrl_pkg::*;
;
  logic              clk = 0;
  logic              rst = 1;
  logic              ce = 1;
  reg_req_t          reg_req;
  logic [7:0]        reg_rdata;
  logic [DATA_W-1:0] sample_data = '0;
  logic              sample_valid = 0;
  logic              sample_ready;
  logic [DATA_W-1:0] out_data;
  logic              out_valid;
  logic              out_ready = 1;
  logic              div_clk_tick;
  logic              dcs_active;
  logic              power_down;
  logic              standby;
  int                n_mismatch = 0;
  int                checks = 0;
  logic [31:0]       seed = 32'hC3C5;
  logic [11:0]       q[$];
  logic [7:0]        d8;
  logic [11:0]       w;
  int                n;
  logic [7:0]  ra[7] = '{8'h08, 8'h09, 8'h0B, 8'h0D, 8'h10, 8'hFF, 8'h42};
  logic [7:0]  rv[7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  ts[11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h09, 8'h0F,
                          8'h25, 8'h16, 8'h82};
  logic [11:0] e0[11] = '{12'h000, 12'h7FF, 12'h800, 12'hAAA, 12'hFFF, 12'h123,
                          12'h000, 12'h000, 12'hFFF, 12'h1FF, 12'h7FF};
  logic [11:0] e1[11] = '{12'h000, 12'h7FF, 12'h800, 12'h555, 12'h000, 12'h123,
                          12'h000, 12'h001, 12'hFFF, 12'h1FF, 12'h000};

  always #2.5 clk = ~clk;

  adc_control_register_bank dut (.clk(clk), .rst(rst), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .div_clk_tick(div_clk_tick), .dcs_active(dcs_active),
    .power_down(power_down), .standby(standby));

  reg_host host (.clk(clk), .rdata(reg_rdata), .req(reg_req));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [11:0] sat(input logic [11:0] s, input logic [5:0] o);
    int v;
    v = $signed(s) + $signed(o);
    if (v > 2047) v = 2047;
    if (v < -2048) v = -2048;
    return v[11:0];
  endfunction

  // ==========================================================================
  // Stimulus helpers
  task automatic send(input logic [11:0] s, input logic [11:0] e);
    q.push_back(e);
    @(posedge clk) #1 sample_valid = 1;
    sample_data = s;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (sample_ready === 1'b1) break;
    end
    #1 sample_valid = 0;
    sample_data = ~s;
  endtask

  task automatic set(input logic [7:0] a, input logic [7:0] d, input bit drain);
    for (int i = 0; i < 400 && drain && q.size() != 0; i++) @(posedge clk);
    host.wr(a, d);
    host.commit();
    repeat (2) @(posedge clk);
  endtask

  task automatic period(input int e);
    int c;
    c = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (div_clk_tick === 1'b1) break;
    end
    do begin
      @(posedge clk);
      c++;
    end while (div_clk_tick !== 1'b1 && c < 40);
    `CHK("tick period", e, c)
  endtask

  task automatic lag(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (div_clk_tick !== 1'b1 && c < 40);
  endtask

  task end_of_test;
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Output watcher and back-pressure
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (q.size() == 0) begin
        `CHK("extra word", 1'b0, 1'b1)
      end else begin
        w = q.pop_front();
        `CHK("out_data", w, out_data)
      end
    end
  end

  always @(posedge clk) begin
    #1 seed = lfsr(seed);
    out_ready = seed[0] | seed[3];
  end

  initial begin
    #200000;
    n_mismatch++;
    end_of_test;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 7; i++) begin
      host.rd(ra[i], d8);
      `CHK("reset value", rv[i], d8)
    end
    `CHK("dcs after reset", 1'b1, dcs_active)
    host.wr(ADDR_OFFSET, 8'h05);
    send(12'h100, 12'h100);
    set(ADDR_OFFSET, 8'h05, 1);
    host.rd(ADDR_COMMIT, d8);
    `CHK("commit readback", 8'h00, d8)
    send(12'h7FE, 12'h7FF);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      send(seed[11:0], sat(seed[11:0], 6'h05));
    end
    set(ADDR_OFFSET, 8'h20, 1);
    send(12'h801, 12'h800);
    host.wr(ADDR_OFFSET, 8'hFF);
    host.rd(ADDR_OFFSET, d8);
    `CHK("offset width", 8'h3F, d8)
    host.wr(ADDR_USER1_LO, 8'h30);
    host.wr(ADDR_USER1_HI, 8'h12);
    set(ADDR_OFFSET, 8'h00, 1);
    for (int i = 0; i < 11; i++) begin
      set(ADDR_TEST, ts[i], 1);
      seed = lfsr(seed);
      send(seed[11:0], e0[i]);
      send(~seed[11:0], e1[i]);
    end
    host.rd(ADDR_TEST, d8);
    `CHK("test readback", 8'h82, d8)
    host.wr(ADDR_TEST, 8'h00);
    set(ADDR_POWER, 8'h01, 1);
    `CHK("power_down", 1'b1, power_down)
    n = 0;
    @(posedge clk) #1 sample_valid = 1;
    sample_data = 12'h040;
    repeat (12) begin
      @(posedge clk);
      if (sample_ready === 1'b1) begin
        q.push_back(sample_data);
        n++;
        #1 sample_data++;
      end
    end
    #1 sample_valid = 0;
    `CHK("fifo fill", 8, n)
    set(ADDR_POWER, 8'h02, 0);
    `CHK("standby", 2'b10, {standby, power_down})
    set(ADDR_POWER, 8'h00, 1);
    send(12'h321, 12'h321);
    set(ADDR_CLK_STAB, 8'h00, 1);
    `CHK("dcs cleared", 1'b0, dcs_active)
    set(ADDR_CLK_DIV, 8'h07, 1);
    `CHK("dcs forced", 1'b1, dcs_active)
    lag(n);
    `CHK("tick lag", 1, n)
    period(8);
    #1 ce = 0;
    repeat (10) @(posedge clk);
    #1 ce = 1;
    lag(n);
    `CHK("frozen tick", 8, n)
    set(ADDR_CLK_DIV, 8'h3A, 1);
    lag(n);
    `CHK("tick lag", 8, n)
    period(3);
    set(ADDR_CLK_DIV, 8'h00, 1);
    `CHK("dcs released", 1'b0, dcs_active)
    period(1);
    set(ADDR_TEST, 8'h00, 1);
    `CHK("words left", 0, q.size())
    end_of_test;
  end
endmodule
